// ==== irq_indirect_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte registers on a plain port with 8-bit address
// Notes: definitions only
`ifndef IRQ_INDIRECT_CFG_SVH
`define IRQ_INDIRECT_CFG_SVH
`define OFS_IRQ_STATUS1 8'h12
`define OFS_IRQ_STATUS2 8'h13
`define OFS_IRQ_STATUS3 8'h14
`define OFS_TIMER_EN 8'h15
`define OFS_ALARM_EN 8'h16
`define OFS_IND_DONE_EN 8'h17
`define OFS_IND_DATA_LO 8'h1C
`define OFS_IND_DATA_HI 8'h1D
`define OFS_IND_ADDR 8'h1E
`define OFS_IND_STATUS 8'h1F
`define TIMER_EN_MASK 8'h3F
`define IND_DONE_BIT 1
`define IND_SPARE_BIT 0
`define IND_BUSY_BIT 0
`define DATA_LO_RESET 8'h00
`define CLK_HZ 50000000
`define UPDATE_HZ 16000
`define UPDATE_CYCLES (`CLK_HZ / `UPDATE_HZ)
`endif

// ==== irq_indirect_pkg.sv ====
// Purpose: types shared by the indirect access block
// Assumes: constants live in irq_indirect_cfg.svh
// Notes: none
package irq_indirect_pkg;
  typedef enum logic [1:0] {
    IND_IDLE = 2'b01,
    IND_PEND = 2'b10
  } ind_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [5:0] timer;
    logic [7:0] alarm;
    logic done;
  } irq_evt_s;

  typedef struct packed {
    ind_state_e st;
    logic is_write;
    logic data_written;
    logic [12:0] tick_cnt;
    logic [7:0] timer_en;
    logic [7:0] alarm_en;
    logic [1:0] done_en;
    logic [5:0] timer_pend;
    logic [7:0] alarm_pend;
    logic done_pend;
    logic [15:0] data;
    logic [7:0] addr;
    logic [7:0] rdata;
  } state_s;
endpackage

// ==== irq_mask_indirect_access.sv ====
// Purpose: interrupt enables, pending flags and indirect access port
// Assumes: one clock, synchronous active-high reset, 8-bit registers
// Notes: indirect memory is held locally as a 256-word array
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "irq_indirect_cfg.svh"

module irq_mask_indirect_access #(
  parameter int unsigned UPDATE_PERIOD = `UPDATE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event pulses from the line logic
  input wire logic [5:0] timer_evt,
  input wire logic [7:0] alarm_evt,
  // Interrupt and status
  output logic irq,
  output logic indirect_busy_status
);
  irq_indirect_pkg::state_s cur, next_cur;
  irq_indirect_pkg::reg_req_s req;
  irq_indirect_pkg::irq_evt_s en_vec, pend_vec;
  logic [15:0] mem [0:255];
  logic tick;
  logic mem_we;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs,
                               input logic s);
    hit = s && (a == ofs);
  endfunction

  assign tick = (cur.tick_cnt == 13'(UPDATE_PERIOD - 1));
  assign mem_we = tick && (cur.st == irq_indirect_pkg::IND_PEND)
                  && cur.is_write;

  always_comb begin
    en_vec.timer = cur.timer_en[5:0];
    en_vec.alarm = cur.alarm_en;
    en_vec.done = cur.done_en[`IND_DONE_BIT];
    pend_vec.timer = cur.timer_pend;
    pend_vec.alarm = cur.alarm_pend;
    pend_vec.done = cur.done_pend;
  end

  always_comb begin
    next_cur = cur;
    next_cur.tick_cnt = tick ? 13'h0000 : cur.tick_cnt + 13'h0001;
    // Event set wins over a write-one clear in the same cycle
    if (hit(req.addr, `OFS_IRQ_STATUS1, req.wr)) begin
      next_cur.timer_pend = cur.timer_pend & ~req.wdata[5:0];
    end
    if (hit(req.addr, `OFS_IRQ_STATUS2, req.wr)) begin
      next_cur.alarm_pend = cur.alarm_pend & ~req.wdata;
    end
    if (hit(req.addr, `OFS_IRQ_STATUS3, req.wr)
        && req.wdata[`IND_DONE_BIT]) begin
      next_cur.done_pend = 1'b0;
    end
    next_cur.timer_pend = next_cur.timer_pend | timer_evt;
    next_cur.alarm_pend = next_cur.alarm_pend | alarm_evt;
    if (hit(req.addr, `OFS_TIMER_EN, req.wr)) begin
      next_cur.timer_en = req.wdata;
    end
    if (hit(req.addr, `OFS_ALARM_EN, req.wr)) begin
      next_cur.alarm_en = req.wdata;
    end
    if (hit(req.addr, `OFS_IND_DONE_EN, req.wr)) begin
      next_cur.done_en = req.wdata[1:0];
    end
    if (hit(req.addr, `OFS_IND_DATA_LO, req.wr)) begin
      next_cur.data[7:0] = req.wdata;
      next_cur.data_written = 1'b1;
    end
    if (hit(req.addr, `OFS_IND_DATA_HI, req.wr)) begin
      next_cur.data[15:8] = req.wdata;
      next_cur.data_written = 1'b1;
    end
    unique case (cur.st)
      irq_indirect_pkg::IND_IDLE: begin
        if (hit(req.addr, `OFS_IND_ADDR, req.wr)) begin
          next_cur.addr = req.wdata;
          next_cur.is_write = cur.data_written;
          next_cur.data_written = 1'b0;
          next_cur.st = irq_indirect_pkg::IND_PEND;
        end
      end
      irq_indirect_pkg::IND_PEND: begin
        // Address writes while busy only retarget; host should wait
        if (hit(req.addr, `OFS_IND_ADDR, req.wr)) begin
          next_cur.addr = req.wdata;
        end
        if (tick) begin
          if (!cur.is_write) begin
            next_cur.data = mem[cur.addr];
          end
          next_cur.done_pend = 1'b1;
          next_cur.st = irq_indirect_pkg::IND_IDLE;
        end
      end
    endcase
    next_cur.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `OFS_IRQ_STATUS1: next_cur.rdata = {2'b00, cur.timer_pend};
        `OFS_IRQ_STATUS2: next_cur.rdata = cur.alarm_pend;
        `OFS_IRQ_STATUS3: next_cur.rdata = {6'h00, cur.done_pend, 1'b0};
        `OFS_TIMER_EN: next_cur.rdata = cur.timer_en;
        `OFS_ALARM_EN: next_cur.rdata = cur.alarm_en;
        `OFS_IND_DONE_EN: next_cur.rdata = {6'h00, cur.done_en};
        `OFS_IND_DATA_LO: next_cur.rdata = cur.data[7:0];
        `OFS_IND_DATA_HI: next_cur.rdata = cur.data[15:8];
        `OFS_IND_ADDR: next_cur.rdata = cur.addr;
        `OFS_IND_STATUS: next_cur.rdata =
          {7'h00, cur.st == irq_indirect_pkg::IND_PEND};
        default: next_cur.rdata = 8'h00;
      endcase
    end
    if (rst) begin
      next_cur = '0;
      next_cur.st = irq_indirect_pkg::IND_IDLE;
      next_cur.data[7:0] = `DATA_LO_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    cur <= next_cur;
  end

  // Memory left unreset; its contents are defined only once written
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[cur.addr] <= cur.data;
    end
  end

  assign reg_rdata = cur.rdata;
  assign irq = |(en_vec & pend_vec);
  assign indirect_busy_status = (cur.st == irq_indirect_pkg::IND_PEND);
endmodule

// ==== irq_chk_checker.sv ====
// Purpose: port checker
// Assumes: enables clear at reset
// Notes: bind at foot
`timescale 1ns/100ps
module irq_chk #(
  parameter int unsigned UPDATE_PERIOD = 8
) (
  // Clock
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Line
  input wire logic [5:0] timer_evt,
  input wire logic [7:0] alarm_evt,
  input wire logic irq,
  input wire logic indirect_busy_status
);
  logic [14:0] en;
  // Enable shadow only; pending flags stay hidden
  always_ff @(posedge mclk)
    if (rst) en <= '0;
    else if (reg_wr && reg_addr == 8'h15) en[5:0] <= reg_wdata[5:0];
    else if (reg_wr && reg_addr == 8'h16) en[13:6] <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h17) en[14] <= reg_wdata[1];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_req;
    reg_wr && reg_addr == 8'h1E && !indirect_busy_status;
  endsequence
  sequence s_spare;
    reg_wr && reg_addr == 8'h15 ##2 reg_rd && reg_addr == 8'h15;
  endsequence
  a_spare_rw: assert property (
    s_spare |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 3))
    else $error("spare");
  a_busy_set: assert property (
    s_req |=> indirect_busy_status) else $error("busy");
  a_busy_cause: assert property (
    $rose(indirect_busy_status) |-> $past(reg_wr && reg_addr == 8'h1E))
    else $error("busy cause");
  a_busy_bound: assert property (
    $rose(indirect_busy_status) |-> ##[1:9] !indirect_busy_status)
    else $error("tick late");
  a_mask_all: assert property (
    en == 15'h0000 |-> !irq) else $error("masked");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(reg_wr || timer_evt != 0 || alarm_evt != 0) ||
    $past(indirect_busy_status) || $past(indirect_busy_status, 2))
    else $error("irq cause");
  a_irq_fall: assert property (
    $fell(irq) |-> $past(reg_wr)) else $error("irq fell");
  a_res_zero: assert property (
    reg_rd && reg_addr == 8'h17 |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved");
endmodule
bind irq_mask_indirect_access irq_chk #(.UPDATE_PERIOD(UPDATE_PERIOD))
  u_chk (.*);

// ==== irq_mask_indirect_access_tb.sv ====
// Purpose: bench
// Assumes: update period 8
// Notes: seeded data
`timescale 1ns/100ps
module irq_mask_indirect_access_tb;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq;
  logic indirect_busy_status;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ra, ia, m;
  logic [5:0] timer_evt = 0;
  logic [7:0] alarm_evt = 0;
  logic [15:0] d, mem [int];
  int n_mismatch = 0, num_checks = 0, seed = 32'h81A8E491, i, k;
  always #10 mclk = ~mclk;
  irq_mask_indirect_access #(.UPDATE_PERIOD(8)) u_dut (.*);
  task chk(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
    @(posedge mclk);
  endtask
  task rc(input logic [7:0] a, e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
    @(posedge mclk);
  endtask
  task ind(input logic [7:0] a);
    wr(8'h1E, a);
    // Host waits out the access before touching the port again
    for (k = 0; k < 20 && indirect_busy_status; k++) begin
      @(posedge mclk);
      #1;
    end
    #1 chk({7'h0, indirect_busy_status}, 8'h00);
    rc(8'h1F, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk({7'h0, irq}, 8'h01);
    wr(8'h14, 8'h02);
  endtask
  task ev(input logic [13:0] v);
    {alarm_evt, timer_evt} <= v;
    @(posedge mclk);
    {alarm_evt, timer_evt} <= 14'h0;
    @(posedge mclk);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run is about 250 cycles
  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    rc(8'h1C, 8'h00);
    rc(8'h40, 8'h00);
    for (i = 0; i < 3; i++) begin
      ra = $random(seed);
      m = i == 2 ? ra & 8'h03 : ra;
      wr(8'h15 + 8'(i), ra);
      rc(8'h15 + 8'(i), m);
    end
    for (i = 0; i < 3; i++) wr(8'h15 + 8'(i), 8'h00);
    $display("enables done");
    for (i = 0; i < 14; i++) begin
      ra = i < 6 ? 8'h15 : 8'h16;
      ia = 8'h01 << (i < 6 ? i : i - 6);
      ev(14'h1 << i);
      chk({7'h0, irq}, 8'h00);
      wr(ra, ia);
      #1 chk({7'h0, irq}, 8'h01);
      rc(ra - 8'h03, ia);
      wr(ra - 8'h03, ia);
      rc(ra - 8'h03, 8'h00);
      wr(ra, 8'h00);
    end
    $display("sources done");
    wr(8'h17, 8'h02);
    ia = $random(seed);
    for (i = 0; i < 2; i++) begin
      d = 16'($random(seed));
      mem[ia ^ 8'(i)] = d;
      wr(8'h1C, d[7:0]);
      wr(8'h1D, d[15:8]);
      ind(ia ^ 8'(i));
    end
    ind(ia);
    d = mem[ia];
    rc(8'h1C, d[7:0]);
    rc(8'h1D, d[15:8]);
    rc(8'h1E, ia);
    $display("indirect done");
    test_done();
  end
endmodule
